// >>> rtl/tweh_pkg.sv
// constants, types and states shared by the event handshake block
// assumes an 8-bit register view placed in the low lane of a 32-bit bus
package tweh_pkg;
   // register byte offsets
   localparam logic [7:0] ADR_CTRL = 8'h00;
   localparam logic [7:0] ADR_STAT = 8'h04;
   localparam logic [7:0] ADR_DATA = 8'h08;
   localparam logic [7:0] ADR_RATE = 8'h0C;
   // values after reset
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] DATA_RST = 8'hFF;
   localparam logic [7:0] RATE_RST = 8'h00;
   localparam logic [1:0] PSC_RST  = 2'h0;
   // status codes, prescaler bits masked
   localparam logic [7:0] CODE_START   = 8'h08;
   localparam logic [7:0] CODE_RSTART  = 8'h10;
   localparam logic [7:0] CODE_ADR_ACK = 8'h18;
   localparam logic [7:0] CODE_ADR_NAK = 8'h20;
   localparam logic [7:0] CODE_DAT_ACK = 8'h28;
   localparam logic [7:0] CODE_DAT_NAK = 8'h30;
   localparam logic [7:0] CODE_NONE    = 8'hF8;
   // fixed part of the half bit period, in clock cycles
   localparam logic [15:0] HALF_BASE = 16'h0008;
   // index of the acknowledge bit within a packet
   localparam logic [3:0] ACK_IDX = 4'h8;
   // control register layout
   typedef struct packed {
      logic flag;      // event flag, write one to clear
      logic ack_en;    // acknowledge enable, kept for receive modes
      logic start;     // start request
      logic stop;      // stop request
      logic wcol;      // write collision, read only
      logic en;        // interface enable
      logic rsvd;      // reads zero
      logic ie;        // event interrupt enable
   } tweh_ctrl_t;
   // sequencer states
   typedef enum logic [3:0] {
      S_IDLE, S_START, S_RS_LO, S_RS_HI, S_BIT_LO, S_BIT_HI,
      S_HOLD, S_STOP_LO, S_STOP_HI
   } tweh_state_t;
endpackage

// >>> rtl/tweh_rate.sv
// half bit period tick generator for the bus clock
// assumes i_run is low while the sequencer idles or holds; the count restarts after every tick
`timescale 1ns/1ps
`default_nettype none
module tweh_rate
   import tweh_pkg::*;
#(
   parameter int RATE_W = 8
) (
   // clock and reset
   input  wire logic              i_clk,
   input  wire logic              i_nrst,
   // settings
   input  wire logic [RATE_W-1:0] i_rate,
   input  wire logic [1:0]        i_psc,
   // control and tick
   input  wire logic              i_run,
   output logic                   o_tick
);
   logic [15:0] cnt_q;    // cycles spent in this phase
   wire  [15:0] scaled;   // rate times four to the prescaler
   wire  [15:0] limit;    // half period in cycles
   assign scaled = 16'(i_rate) << {i_psc, 1'b0};
   assign limit  = HALF_BASE + scaled;
   // count while running, pulse once at the limit
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         cnt_q  <= 16'h0000;
         o_tick <= 1'b0;
      end else if (!i_run || o_tick) begin
         cnt_q  <= 16'h0000;
         o_tick <= 1'b0;
      end else begin
         cnt_q  <= cnt_q + 16'h0001;
         o_tick <= (cnt_q + 16'h0001) >= (limit - 16'h0001);
      end
   end
endmodule
`default_nettype wire

// >>> rtl/tweh_sync.sv
// two flip-flop synchroniser for the bus pin inputs
// assumes inputs are asynchronous to the system clock
`timescale 1ns/1ps
`default_nettype none
module tweh_sync #(
   parameter int W = 2
) (
   // clock and reset
   input  wire logic         i_clk,
   input  wire logic         i_nrst,
   // pins in, levels out
   input  wire logic [W-1:0] i_async,
   output logic      [W-1:0] o_sync
);
   logic [W-1:0] meta_q;   // first stage, read only by second
   // both stages idle high like a pulled-up bus
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         meta_q <= '1;
         o_sync <= '1;
      end else begin
         meta_q <= i_async;
         o_sync <= meta_q;
      end
   end
endmodule
`default_nettype wire

// >>> rtl/tweh_top.sv
// two-wire master event handshake with a classic Wishbone register port
// assumes pulled-up open-drain lines and a same-clock global irq enable
// Behaviour
// R1 - flag an event after every byte-level bus event
// R2 - irq needs flag, local and global enable
// R3 - software polls flag when irq disabled
// R4 - status holds bus code while flag set
// R5 - writing one clears flag, zero keeps
// R6 - no new bus operation while flag set
// R7 - clearing flag starts written operation at once
// R8 - start sent sets flag with start code
// R9 - address sent sets flag, code shows ack
// R10 - data sent sets flag, code shows ack
// R11 - stop completion leaves flag clear
// R12 - clock line held low while flag set
// R13 - one shift register for address and data
// R14 - software loads registers before clearing flag
// R15 - software masks prescaler bits before comparing
// R16 - software checks code, errors on mismatch
// R17 - software sequence start, address, data, stop
// R18 - command bits taken from the clearing write
// R19 - start code reads hex 08
// R20 - data write with flag clear ignored, collision
// R21 - stop written with flag, stop, enable
// R22 - flag clear shows no-status code
//
// Chosen here: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module tweh_top
   import tweh_pkg::*;
#(
   parameter int RATE_W = 8,
   parameter int ADR_W  = 8
) (
   // system clock and reset
   input  wire logic             I_CLK_SYS,
   input  wire logic             I_NRST,
   // wishbone slave
   input  wire logic             I_WB_CYC,
   input  wire logic             I_WB_STB,
   input  wire logic             I_WB_WE,
   input  wire logic [ADR_W-1:0] I_WB_ADR,
   input  wire logic [3:0]       I_WB_SEL,
   input  wire logic [31:0]      I_WB_DAT,
   output logic      [31:0]      O_WB_DAT,
   output logic                  O_WB_ACK,
   // cpu global interrupt enable and request
   input  wire logic             I_GIE,
   output logic                  O_IRQ,
   // clock line, open drain
   input  wire logic             I_SCL,
   output logic                  O_SCL,
   output logic                  O_SCL_OE,
   // data line, open drain
   input  wire logic             I_SDA,
   output logic                  O_SDA,
   output logic                  O_SDA_OE
);
   // synchronised pins
   logic [1:0] pin_s;        // {scl, sda}
   wire        scl_s;        // clock line level
   wire        sda_s;        // data line level
   assign scl_s = pin_s[1];
   assign sda_s = pin_s[0];

   tweh_sync #(
      .W(2)
   ) u_sync (
      .i_clk  (I_CLK_SYS),
      .i_nrst (I_NRST),
      .i_async({I_SCL, I_SDA}),
      .o_sync (pin_s)
   );

   // registers
   tweh_ctrl_t        ctrl_q, ctrl_d;   // control register
   logic [7:0]        data_q, data_d;   // shift data register
   logic [RATE_W-1:0] rate_q, rate_d;   // bit rate register
   logic [1:0]        psc_q, psc_d;     // prescaler bits
   logic [7:0]        code_q, code_d;   // posted status code
   tweh_state_t       st_q, st_d;       // sequencer state
   logic [3:0]        idx_q, idx_d;     // bit index in packet
   logic              adr_q, adr_d;     // next packet is address
   logic              pend_q, pend_d;   // start waiting for free bus
   logic              rs_q, rs_d;       // start is a repeated one
   logic              scl_lo_q, scl_lo_d;
   logic              sda_lo_q, sda_lo_d;
   logic              ack_q;            // bus acknowledge
   logic [31:0]       rdat_q;           // bus read data
   logic              irq_q;            // interrupt request
   logic              tick;             // half period elapsed

   // bus decode
   wire req     = I_WB_CYC & I_WB_STB;
   wire wr      = req & I_WB_WE & ack_q & I_WB_SEL[0];
   wire hit_ctl = (I_WB_ADR == ADR_W'(ADR_CTRL));
   wire hit_st  = (I_WB_ADR == ADR_W'(ADR_STAT));
   wire hit_dat = (I_WB_ADR == ADR_W'(ADR_DATA));
   wire hit_rt  = (I_WB_ADR == ADR_W'(ADR_RATE));
   wire wr_ctl  = wr & hit_ctl;
   wire wr_dat  = wr & hit_dat;
   wire wr_rt   = wr & hit_rt;
   wire wr_st   = wr & hit_st;
   wire [7:0] wd = I_WB_DAT[7:0];
   tweh_ctrl_t wc;                      // written control view
   assign wc = tweh_ctrl_t'(wd);

   // command decode from the clearing write
   wire go      = wr_ctl & wc.flag & wc.en;                  // R18
   wire go_st   = go & wc.start;
   wire go_sp   = go & wc.stop;
   wire go_byte = go & ~wc.start & ~wc.stop;

   // status view: code only while flag set
   wire [7:0] stat_rd = {ctrl_q.flag ? code_q[7:3]          // R4
                                     : CODE_NONE[7:3],      // R22
                         1'b0, psc_q};
   wire [7:0] ctrl_rd = {ctrl_q.flag, ctrl_q.ack_en, ctrl_q.start,
                         ctrl_q.stop, ctrl_q.wcol, ctrl_q.en,
                         1'b0, ctrl_q.ie};
   wire [7:0] rd_sel  = hit_ctl ? ctrl_rd
                      : hit_st  ? stat_rd
                      : hit_dat ? data_q
                      : hit_rt  ? 8'(rate_q)
                      : 8'h00;

   // tick generator runs outside idle and hold, except while a slave stretches
   wire hi_wait = (st_q == S_BIT_HI) | (st_q == S_RS_HI)
                | (st_q == S_STOP_HI);
   wire run     = (st_q != S_IDLE) & (st_q != S_HOLD)
                & ~(hi_wait & ~scl_s);

   tweh_rate #(
      .RATE_W(RATE_W)
   ) u_rate (
      .i_clk (I_CLK_SYS),
      .i_nrst(I_NRST),
      .i_rate(rate_q),
      .i_psc (psc_q),
      .i_run (run),
      .o_tick(tick)
   );

   // event when a flagged step finishes
   logic set_evt;           // raise the flag this cycle

   // sequencer and register next values
   always_comb begin
      st_d     = st_q;
      idx_d    = idx_q;
      adr_d    = adr_q;
      pend_d   = pend_q;
      rs_d     = rs_q;
      code_d   = code_q;
      data_d   = data_q;
      set_evt  = 1'b0;
      ctrl_d   = ctrl_q;
      rate_d   = wr_rt ? wd[RATE_W-1:0] : rate_q;
      psc_d    = wr_st ? wd[1:0] : psc_q;
      // software side of control
      if (wr_ctl) begin
         ctrl_d.ack_en = wc.ack_en;
         ctrl_d.start  = wc.start;
         ctrl_d.stop   = wc.stop;
         ctrl_d.en     = wc.en;
         ctrl_d.ie     = wc.ie;
      end
      // data writes only land while flag set
      if (wr_dat) begin
         if (ctrl_q.flag) begin
            data_d       = wd;                              // R14
            ctrl_d.wcol  = 1'b0;
         end else begin
            ctrl_d.wcol  = 1'b1;                            // R20
         end
      end
      case (st_q)
         S_IDLE: begin
            // start waits until the bus is free
            if (go_st) begin
               pend_d = 1'b1;                               // R7
            end
            if ((pend_q | go_st) & scl_s & sda_s) begin
               pend_d = 1'b0;
               rs_d   = 1'b0;
               st_d   = S_START;
            end
         end
         S_HOLD: begin
            // waits here for the clearing write
            if (go_sp) begin
               st_d   = S_STOP_LO;                          // R7
               pend_d = wc.start;
            end else if (go_st) begin
               st_d   = S_RS_LO;
            end else if (go_byte) begin
               st_d   = S_BIT_LO;
               idx_d  = 4'h0;
            end
         end
         S_RS_LO: begin
            // release data with clock low
            if (tick) begin
               st_d = S_RS_HI;
            end
         end
         S_RS_HI: begin
            // release clock, then start
            if (tick) begin
               rs_d = 1'b1;
               st_d = S_START;
            end
         end
         S_START: begin
            // data low under high clock
            if (tick) begin
               st_d    = S_HOLD;
               adr_d   = 1'b1;
               set_evt = 1'b1;                              // R8
               code_d  = rs_q ? CODE_RSTART : CODE_START;   // R19
            end
         end
         S_BIT_LO: begin
            // clock low, data settles
            if (tick) begin
               st_d = S_BIT_HI;
            end
         end
         S_BIT_HI: begin
            // sample at end of high phase
            if (tick) begin
               if (idx_q == ACK_IDX) begin
                  st_d    = S_HOLD;
                  adr_d   = 1'b0;
                  set_evt = 1'b1;                           // R1
                  if (adr_q) begin
                     code_d = sda_s ? CODE_ADR_NAK          // R9
                                    : CODE_ADR_ACK;
                  end else begin
                     code_d = sda_s ? CODE_DAT_NAK          // R10
                                    : CODE_DAT_ACK;
                  end
               end else begin
                  data_d = {data_q[6:0], sda_s};            // R13
                  idx_d  = idx_q + 4'h1;
                  st_d   = S_BIT_LO;
               end
            end
         end
         S_STOP_LO: begin
            // data low with clock low
            if (tick) begin
               st_d = S_STOP_HI;
            end
         end
         S_STOP_HI: begin
            // data rises after clock is high
            if (tick) begin
               st_d        = S_IDLE;                        // R11
               ctrl_d.stop = 1'b0;
            end
         end
         default: begin
            st_d = S_IDLE;
         end
      endcase
      // disabling aborts and frees the bus
      if (!ctrl_d.en) begin
         st_d   = S_IDLE;
         pend_d = 1'b0;
      end
      // set wins over the clearing write
      if (set_evt) begin
         ctrl_d.flag = 1'b1;
      end else if (wr_ctl & wc.flag) begin
         ctrl_d.flag = 1'b0;                                // R5
      end
   end

   // line drive from the next state
   always_comb begin
      scl_lo_d = 1'b0;
      sda_lo_d = 1'b0;
      case (st_d)
         S_HOLD: begin
            scl_lo_d = 1'b1;                                // R12
            sda_lo_d = sda_lo_q;
         end
         S_START: begin
            sda_lo_d = 1'b1;
         end
         S_RS_LO: begin
            scl_lo_d = 1'b1;
         end
         S_BIT_LO: begin
            scl_lo_d = 1'b1;
            // data moves only once the clock line is already low
            sda_lo_d = scl_lo_q ? (idx_d != ACK_IDX) & ~data_d[7] : sda_lo_q;
         end
         S_BIT_HI: begin
            sda_lo_d = (idx_d != ACK_IDX) & ~data_d[7];
         end
         S_STOP_LO: begin
            scl_lo_d = 1'b1;
            sda_lo_d = 1'b1;
         end
         S_STOP_HI: begin
            sda_lo_d = 1'b1;
         end
         default: begin
            scl_lo_d = 1'b0;
         end
      endcase
   end

   // bus slave: ack one cycle after request, writes on ack edge
   always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
      if (!I_NRST) begin
         ack_q  <= 1'b0;
         rdat_q <= 32'h0000_0000;
      end else begin
         ack_q  <= req & ~ack_q;
         rdat_q <= {24'h00_0000, rd_sel};
      end
   end

   // control and data registers
   always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
      if (!I_NRST) begin
         ctrl_q <= tweh_ctrl_t'(CTRL_RST);
         data_q <= DATA_RST;
         rate_q <= RATE_W'(RATE_RST);
         psc_q  <= PSC_RST;
         code_q <= CODE_NONE;
      end else begin
         ctrl_q <= ctrl_d;
         data_q <= data_d;
         rate_q <= rate_d;
         psc_q  <= psc_d;
         code_q <= code_d;
      end
   end

   // sequencer registers
   always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
      if (!I_NRST) begin
         st_q   <= S_IDLE;
         idx_q  <= 4'h0;
         adr_q  <= 1'b0;
         pend_q <= 1'b0;
         rs_q   <= 1'b0;
      end else begin
         st_q   <= st_d;                                    // R6
         idx_q  <= idx_d;
         adr_q  <= adr_d;
         pend_q <= pend_d;
         rs_q   <= rs_d;
      end
   end

   // pin drive and interrupt request
   always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
      if (!I_NRST) begin
         scl_lo_q <= 1'b0;
         sda_lo_q <= 1'b0;
         irq_q    <= 1'b0;
      end else begin
         scl_lo_q <= scl_lo_d;
         sda_lo_q <= sda_lo_d;
         irq_q    <= ctrl_d.flag & ctrl_d.ie & I_GIE;       // R2
      end
   end

   // outputs straight from flip-flops, line output values tied low
   assign O_WB_ACK = ack_q;
   assign O_WB_DAT = rdat_q;
   assign O_IRQ    = irq_q;
   assign O_SCL    = 1'b0;
   assign O_SDA    = 1'b0;
   assign O_SCL_OE = scl_lo_q;
   assign O_SDA_OE = sda_lo_q;
endmodule
`default_nettype wire

// >>> sim/tweh_checker.sv
// port-level assertions for the two-wire event handshake block
// assumes single clock domain; bound to every tweh_top instance
`timescale 1ns/1ps
`default_nettype none
module tweh_checker (
   // clock and reset
   input wire logic        I_CLK_SYS,
   input wire logic        I_NRST,
   // wishbone
   input wire logic        I_WB_CYC,
   input wire logic        I_WB_STB,
   input wire logic        I_WB_WE,
   input wire logic [31:0] O_WB_DAT,
   input wire logic        O_WB_ACK,
   // interrupt
   input wire logic        I_GIE,
   input wire logic        O_IRQ,
   // bus lines
   input wire logic        I_SCL,
   input wire logic        O_SCL,
   input wire logic        O_SCL_OE,
   input wire logic        I_SDA,
   input wire logic        O_SDA,
   input wire logic        O_SDA_OE
);
   // write request present on the bus
   logic wr_req;
   assign wr_req = I_WB_CYC & I_WB_STB & I_WB_WE;
   default clocking cb @(posedge I_CLK_SYS); endclocking
   default disable iff (!I_NRST);
   property p_ack_once; I_WB_CYC && I_WB_STB && !O_WB_ACK |=> O_WB_ACK; endproperty
   property p_ack_pulse; O_WB_ACK |=> !O_WB_ACK; endproperty
   property p_ack_cause; O_WB_ACK |-> $past(I_WB_CYC && I_WB_STB); endproperty
   property p_dat_hi; O_WB_ACK |-> O_WB_DAT[31:8] == 24'h000000; endproperty
   property p_gie_off; !I_GIE |=> !O_IRQ; endproperty
   property p_irq_hold; O_IRQ && I_GIE && !wr_req && !$past(wr_req) |=> O_IRQ; endproperty
   property p_hold_lines;
      O_IRQ && $past(O_IRQ) && !$past(wr_req) && !$past(wr_req, 2) |-> $stable(O_SDA_OE) && O_SCL_OE;
   endproperty
   property p_stop_noflag; $rose(I_SDA) && I_SCL && $past(I_SCL) |=> !O_IRQ [*8]; endproperty
   property p_drv_zero; !O_SCL && !O_SDA; endproperty
   a_ack_once: assert property (p_ack_once) else $error("no ack one cycle after request");
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
   a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
   a_dat_hi: assert property (p_dat_hi) else $error("upper read data not zero");
   a_gie_off: assert property (p_gie_off) else $error("irq with global enable low");
   a_irq_hold: assert property (p_irq_hold) else $error("flag dropped without write");
   a_hold_lines: assert property (p_hold_lines) else $error("bus moved while flag set");
   a_stop_noflag: assert property (p_stop_noflag) else $error("flag after stop");
   a_drv_zero: assert property (p_drv_zero) else $error("line output value not zero");
   // main scenarios
   c_irq: cover property ($rose(O_IRQ));
   c_stop: cover property ($rose(I_SDA) && I_SCL);
   c_wr_ack: cover property (O_WB_ACK && $past(I_WB_WE));
endmodule
bind tweh_top tweh_checker i_tweh_checker (.I_CLK_SYS(I_CLK_SYS), .I_NRST(I_NRST), .I_WB_CYC(I_WB_CYC),
   .I_WB_STB(I_WB_STB), .I_WB_WE(I_WB_WE), .O_WB_DAT(O_WB_DAT), .O_WB_ACK(O_WB_ACK), .I_GIE(I_GIE),
   .O_IRQ(O_IRQ), .I_SCL(I_SCL), .O_SCL(O_SCL), .O_SCL_OE(O_SCL_OE), .I_SDA(I_SDA), .O_SDA(O_SDA),
   .O_SDA_OE(O_SDA_OE));
`default_nettype wire

// >>> sim/tweh_slave.sv
// behavioural receiving slave on the two-wire bus
// assumes wired lines with pull-ups resolved by the bench
`timescale 1ns/1ps
`default_nettype none
module tweh_slave (
   // wired line levels
   input  wire logic       scl,
   input  wire logic       sda,
   // behaviour selects
   input  wire logic       nak,
   input  wire logic       slow,
   // drives, high pulls low
   output logic            scl_oe,
   output logic            sda_oe,
   // last received byte
   output logic [7:0]      rx_byte
);
   int         n;   // bit counter within a packet
   logic [7:0] sh;  // incoming shift
   initial begin
      n = 0;
      sh = 8'h00;
      scl_oe = 1'b0;
      sda_oe = 1'b0;
      rx_byte = 8'h00;
   end
   // start or stop restarts packet framing
   always @(sda) if (scl) n = 0;
   // sample data on rising clock, msb first
   always @(posedge scl) if (n < 8) begin
      sh = {sh[6:0], sda};
      n = n + 1;
      if (n == 8) rx_byte = sh;
   end
   // drive ack in ninth low phase, optionally stretching the clock
   always @(negedge scl) if (n == 8) begin
      sda_oe = !nak;
      n = 9;
      if (slow) begin
         scl_oe = 1'b1;
         #300 scl_oe = 1'b0;
      end
   end else if (n == 9) begin
      sda_oe = 1'b0;
      n = 0;
   end
endmodule
`default_nettype wire

// >>> sim/two_wire_event_handshake_test.sv
// self-checking bench: registers, collision, full one-byte writes
// assumes tweh_top with default parameters and a pulled-up bus
`timescale 1ns/1ps
`default_nettype none
module two_wire_event_handshake_test;
   import tweh_pkg::*;
   logic        clk, nrst, cyc, stb, we, gie, nak, slow;  // bench drives
   logic [7:0]  adr;                                      // bus address
   logic [31:0] wdat, rdat;                               // bus data
   logic        ack, irq, scl_oe, sda_oe, s_scl_oe, s_sda_oe, so, dd;
   logic        scl_w, sda_w;                             // wired levels
   logic [7:0]  rx;                                       // slave capture
   int          fail_count, checked;                      // counters
   assign scl_w = ~(scl_oe | s_scl_oe);
   assign sda_w = ~(sda_oe | s_sda_oe);
   tweh_top i_tweh_top (.I_CLK_SYS(clk), .I_NRST(nrst), .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we),
      .I_WB_ADR(adr), .I_WB_SEL(4'hF), .I_WB_DAT(wdat), .O_WB_DAT(rdat), .O_WB_ACK(ack), .I_GIE(gie),
      .O_IRQ(irq), .I_SCL(scl_w), .O_SCL(so), .O_SCL_OE(scl_oe), .I_SDA(sda_w), .O_SDA(dd), .O_SDA_OE(sda_oe));
   tweh_slave i_tweh_slave (.scl(scl_w), .sda(sda_w), .nak(nak), .slow(slow), .scl_oe(s_scl_oe),
      .sda_oe(s_sda_oe), .rx_byte(rx));
   // 100 MHz clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // compare and count
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   // one classic wishbone cycle, waits for ack
   task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= {24'h000000, d};
      @(posedge clk);
      while (ack !== 1'b1) @(posedge clk);
      q = rdat[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] q);
      wb(1'b0, a, 8'h00, q);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] q;
      wb(1'b1, a, d, q);
   endtask
   // poll the flag until set
   task automatic wait_flag();
      logic [7:0] q;
      q = 8'h00;
      while (q[7] !== 1'b1) rd(ADR_CTRL, q);
   endtask
   // masked status compare
   task automatic chk_stat(input logic [7:0] exp);
      logic [7:0] q;
      rd(ADR_STAT, q);
      chk(q & 8'hF8, exp);
   endtask
   // reset values, unmapped read, write collision
   task automatic t_regs();
      logic [7:0] q;
      rd(ADR_CTRL, q);
      chk(q, CTRL_RST);
      rd(ADR_STAT, q);
      chk(q, 8'hF8);
      rd(ADR_DATA, q);
      chk(q, DATA_RST);
      rd(ADR_RATE, q);
      chk(q, RATE_RST);
      rd(8'h10, q);
      chk(q, 8'h00);
      // rate and prescaler fields, then back to the fast setting
      wr(ADR_RATE, 8'h03);
      rd(ADR_RATE, q);
      chk(q, 8'h03);
      wr(ADR_STAT, 8'h02);
      rd(ADR_STAT, q);
      chk(q, 8'hFA);
      chk_stat(CODE_NONE);
      wr(ADR_RATE, RATE_RST);
      wr(ADR_STAT, 8'h00);
      wr(ADR_DATA, 8'h5A);
      rd(ADR_DATA, q);
      chk(q, DATA_RST);
      rd(ADR_CTRL, q);
      chk(q & 8'h08, 8'h08);
      $display("test regs done");
   endtask
   // start, address, data, stop with given slave answer
   task automatic t_xfer(input logic nk, input logic [7:0] ac, input logic [7:0] dc);
      logic [7:0] q;
      nak = nk;
      slow = !nk;
      wr(ADR_CTRL, 8'hA5);
      wait_flag();
      chk_stat(CODE_START);
      chk({7'h00, irq}, 8'h01);
      wr(ADR_CTRL, 8'h25);
      repeat (40) @(posedge clk);
      chk({7'h00, scl_w}, 8'h00);
      rd(ADR_CTRL, q);
      chk(q & 8'h80, 8'h80);
      chk_stat(CODE_START);
      wr(ADR_DATA, 8'hA4);
      rd(ADR_CTRL, q);
      chk(q & 8'h08, 8'h00);
      wr(ADR_CTRL, 8'h85);
      wait_flag();
      chk_stat(ac);
      chk(rx, 8'hA4);
      rd(ADR_DATA, q);
      chk(q, 8'hA4);
      wr(ADR_DATA, 8'h3C);
      wr(ADR_CTRL, 8'h85);
      wait_flag();
      chk_stat(dc);
      chk(rx, 8'h3C);
      // repeated start before the stop
      wr(ADR_CTRL, 8'hA5);
      wait_flag();
      chk_stat(CODE_RSTART);
      gie <= 1'b0;
      repeat (2) @(posedge clk);
      chk({7'h00, irq}, 8'h00);
      gie <= 1'b1;
      wr(ADR_CTRL, 8'h95);
      repeat (100) @(posedge clk);
      rd(ADR_CTRL, q);
      chk(q & 8'h90, 8'h00);
      chk_stat(CODE_NONE);
      chk({6'h00, scl_w, sda_w}, 8'h03);
      $display("test xfer nak=%0b done", nk);
   endtask
   // verdict
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // watchdog against hangs
   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      finish_test();
   end
   // main sequence
   initial begin
      fail_count = 0;
      checked = 0;
      {cyc, stb, we, nak, slow} = 5'h00;
      adr = 8'h00;
      wdat = 32'h00000000;
      gie = 1'b1;
      nrst = 1'b0;
      repeat (16) @(posedge clk);
      nrst <= 1'b1;
      t_regs();
      t_xfer(1'b0, CODE_ADR_ACK, CODE_DAT_ACK);
      t_xfer(1'b1, CODE_ADR_NAK, CODE_DAT_NAK);
      finish_test();
   end
endmodule
`default_nettype wire
